// *** src/event_group.sv ***
// one latched event register with its enable mask and summary bit
`include "status_map.svh"
module event_group
#(
  parameter int         WIDTH      = `EVT_WIDTH,
  parameter logic [7:0] USED_MASK  = 8'hFF,
  parameter logic [7:0] RESET_VAL  = `EVT_RESET
)
(
  input wire logic    clk,   // block clock
  input wire logic    rst,   // synchronous reset
  event_group_if.group grp   // set, clear and enable traffic
);
  import status_pkg::*;

  logic [7:0] event_reg;
  logic [7:0] event_next;
  logic [7:0] enable_reg;

  generate
    if (WIDTH != 8)
    begin : g_width_check
      $error("event_group supports only 8-bit registers");
    end
  endgenerate

  always_comb
  begin
    event_next = (grp.rd_clr || grp.cls) ? `EVT_RESET : event_reg;
    event_next = (event_next | grp.set_bits) & USED_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      event_reg <= RESET_VAL & USED_MASK;
    else
      event_reg <= event_next;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      enable_reg <= `ENA_RESET;
    else if (grp.ena_wr)
      enable_reg <= grp.ena_data;
  end

  assign grp.event_q  = event_reg;
  assign grp.enable_q = enable_reg;
  assign grp.summary  = |(event_reg & enable_reg);
endmodule

// *** src/event_group_if.sv ***
// carrier between the top and one event register group
interface event_group_if;
  logic [7:0] set_bits;
  logic       rd_clr;
  logic       cls;
  logic       ena_wr;
  logic [7:0] ena_data;
  logic [7:0] event_q;
  logic [7:0] enable_q;
  logic       summary;

  modport owner
  (
    output set_bits, rd_clr, cls, ena_wr, ena_data,
    input  event_q, enable_q, summary
  );

  modport group
  (
    input  set_bits, rd_clr, cls, ena_wr, ena_data,
    output event_q, enable_q, summary
  );
endinterface

// *** src/service_request.sv ***
// master summary and request-service latch from the assembled status byte
`include "status_map.svh"
module service_request
(
  input  wire logic       clk,          // block clock
  input  wire logic       rst,          // synchronous reset
  input  wire logic [7:0] summary_bits, // status byte without bit 6
  input  wire logic [7:0] srq_enable,   // service request enable mask
  input  wire logic       poll,         // serial poll strobe
  output logic            mss,          // master summary
  output logic            rqs           // request-service latch
);
  import status_pkg::*;

  logic mss_reg;
  logic rqs_reg;

  assign mss = |(summary_bits & srq_enable & `SB_SUMMARY_MASK);

  always_ff @(posedge clk)
  begin
    if (rst)
      mss_reg <= 1'b0;
    else
      mss_reg <= mss;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rqs_reg <= 1'b0;
    else if (mss && !mss_reg)
      rqs_reg <= 1'b1;
    else if (poll || !mss)
      rqs_reg <= 1'b0;
  end

  assign rqs = rqs_reg;
endmodule

// *** src/status_map.svh ***
// bit positions, masks and reset values of the status reporting registers
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

`define EVT_WIDTH           8

// status byte bit positions
`define SB_MEAS_SUM_BIT     0
`define SB_SRC_SUM_BIT      1
`define SB_ERRQ_BIT         2
`define SB_OUTQ_BIT         4
`define SB_STD_SUM_BIT      5
`define SB_SERVICE_BIT      6
`define SB_SUMMARY_MASK     8'h37

// standard event bit positions
`define SE_POWER_ON_BIT     7
`define SE_CMD_ERR_BIT      5
`define SE_EXEC_ERR_BIT     4
`define SE_DEV_ERR_BIT      3
`define SE_QUERY_ERR_BIT    2
`define SE_OP_DONE_BIT      0
`define SE_USED_MASK        8'hBD

// source event and condition bit positions
`define SRC_SAMPLING_BIT    7
`define SRC_SWEEP_READY_BIT 5
`define SRC_STORE_BIT       2
`define SRC_TURN_BIT        1
`define SRC_SWEEP_DONE_BIT  0
`define SRC_USED_MASK       8'hA7

// measurement event and condition bit positions
`define MEAS_SAMPLING_BIT   7
`define MEAS_DONE_BIT       6
`define MEAS_OVERRANGE_BIT  5
`define MEAS_HIGH_LIM_BIT   3
`define MEAS_LOW_LIM_BIT    2
`define MEAS_ABOVE_BIT      1
`define MEAS_BELOW_BIT      0
`define MEAS_USED_MASK      8'hEF

// reset values
`define STD_EVT_RESET       8'h80
`define EVT_RESET           8'h00
`define ENA_RESET           8'h00
`define COND_RESET          8'h00

`endif

// *** src/status_pkg.sv ***
// types and shared decode functions of the status reporting block
package status_pkg;

  typedef enum logic [3:0]
  {
    Q_STATUS_BYTE,
    Q_SERIAL_POLL,
    Q_STD_EVENT,
    Q_STD_ENABLE,
    Q_SRQ_ENABLE,
    Q_SRC_COND,
    Q_SRC_EVENT,
    Q_SRC_ENABLE,
    Q_MEAS_COND,
    Q_MEAS_EVENT,
    Q_MEAS_ENABLE
  } query_e;

  typedef enum logic [1:0]
  {
    W_SRQ_ENABLE,
    W_STD_ENABLE,
    W_SRC_ENABLE,
    W_MEAS_ENABLE
  } write_e;

  typedef enum
  {
    OPC_IDLE,
    OPC_WAIT
  } opc_state_e;

  typedef logic [7:0] byte_t;

  // 0-to-1 change detector, shared by the source and measurement condition bits
  function automatic byte_t rise(input byte_t cur, input byte_t prev);
    rise = cur & ~prev;
  endfunction

endpackage

// *** src/status_report.sv ***
// status reporting block: event registers, status byte and service request
`include "status_map.svh"

// Functional notes
// - bit 6 is set when any other status bit meets its request enable
// - bit 5 is the masked OR of the standard event register
// - status byte query returns master summary in bit 6, clears nothing
// - serial poll returns the request latch in bit 6, then clears only it
// - no operation clears the whole status byte at once
// - clear-status clears event registers, leaves message-available alone
// - clear-status right after a message terminator also flushes output queue
// - power-on sets standard event bit 7
// - command syntax error sets standard event bit 5
// - execution error sets standard event bit 4
// - internal device fault sets standard event bit 3
// - missing or lost response data sets standard event bit 2
// - bit 0 sets once operations pending before the completion command finish
// - standard event bits 6 and 1 always read zero
// - standard event register clears on read, clear-status and power cycle
// - early trigger sets bit 7 in source and measurement event registers
// - sweep-ready condition tracks readiness, event latches on its rise
// - store, sweep turn and sweep end set source bits 2,1,0; 6,4,3 zero
// - event reads clear, condition reads do not; source clears on clear-status
// - measurement done sets measurement bit 6; bit 4 reads zero
// - measurement condition bits track live state, events latch on rises
// - an event reaches its summary only while its enable bit is one
// - source summary in status bit 1, measurement summary in bit 0
// - bit 2 error queue, bit 4 output queue non-empty; bits 3,7 zero
// - request latch sets on summary rise, clears on poll or summary fall
// - measurement event register clears on read, clear-status and power cycle
module status_report
(
  input  wire logic                 REF_CLK,          // 125 MHz block clock
  input  wire logic                 RST,              // synchronous reset, power cycle
  input  wire logic                 QUERY_STB,        // one-cycle query request
  input  wire status_pkg::query_e   QUERY_SEL,        // which register is queried
  input  wire logic                 WR_STB,           // one-cycle enable write
  input  wire status_pkg::write_e   WR_SEL,           // which enable is written
  input  wire logic [7:0]           WR_DATA,          // enable write value
  input  wire logic                 CLS_STB,          // clear-status command
  input  wire logic                 AFTER_TERMINATOR, // last message ended in terminator
  input  wire logic                 CMD_ERR,          // syntax error pulse
  input  wire logic                 EXEC_ERR,         // execution error pulse
  input  wire logic                 DEV_ERR,          // internal fault pulse
  input  wire logic                 QUERY_ERR,        // response lost pulse
  input  wire logic                 OPC_CMD,          // operation-complete command pulse
  input  wire logic                 OPS_IDLE,         // no earlier operation pending
  input  wire logic                 ERR_QUEUE_NONEMPTY,  // error queue level
  input  wire logic                 OUT_QUEUE_NONEMPTY,  // output queue level
  input  wire logic                 TRIG_EARLY,       // trigger before cycle end pulse
  input  wire logic                 SWEEP_READY,      // sweep start acceptable level
  input  wire logic                 STORE_DONE,       // store finished pulse
  input  wire logic                 SWEEP_TURN_DONE,  // sweep turn finished pulse
  input  wire logic                 SWEEP_DONE,       // whole sweep finished pulse
  input  wire logic                 MEASUREMENT_DONE, // measurement complete pulse
  input  wire logic                 OVERRANGE_FLAG,   // overrange level
  input  wire logic                 HIGH_LIMITER_ACTIVE, // high limiter level
  input  wire logic                 LOW_LIMITER_ACTIVE,  // low limiter level
  input  wire logic                 COMPARE_ABOVE,    // compare high level
  input  wire logic                 COMPARE_BELOW,    // compare low level
  output logic [7:0]                RD_DATA,          // query answer, registered
  output logic                      RD_VALID,         // answer strobe, registered
  output logic                      OUT_QUEUE_FLUSH,  // empty output queue pulse
  output logic                      SRQ               // service request, latch level
);
  import status_pkg::*;

  event_group_if std_if ();
  event_group_if src_if ();
  event_group_if meas_if ();

  logic [7:0]  src_cond_reg;
  logic [7:0]  src_cond_next;
  logic [7:0]  meas_cond_reg;
  logic [7:0]  meas_cond_next;
  logic [7:0]  srq_enable_reg;
  logic [7:0]  status_byte;
  logic [7:0]  rd_data_reg;
  logic [7:0]  rd_data_next;
  logic        rd_valid_reg;
  logic        flush_reg;
  logic        mss;
  logic        rqs;
  logic        is_poll;
  logic        opc_fire;
  opc_state_e  opc_state_reg;
  opc_state_e  opc_state_next;

  // query decode, used for read clears and for the serial poll strobe
  function automatic logic queried(input logic stb, input query_e sel, input query_e which);
    queried = stb && (sel == which);
  endfunction

  function automatic logic written(input logic stb, input write_e sel, input write_e which);
    written = stb && (sel == which);
  endfunction

  assign is_poll = queried(QUERY_STB, QUERY_SEL, Q_SERIAL_POLL);

  // ---------------- operation complete tracking ----------------
  // an operation-complete command waits for earlier work to drain
  always_comb
  begin
    opc_state_next = opc_state_reg;
    opc_fire       = 1'b0;
    case (opc_state_reg)
      OPC_IDLE:
      begin
        if (OPC_CMD && OPS_IDLE)
          opc_fire = 1'b1;
        else if (OPC_CMD)
          opc_state_next = OPC_WAIT;
      end
      OPC_WAIT:
      begin
        if (OPS_IDLE)
        begin
          opc_fire       = 1'b1;
          opc_state_next = OPC_IDLE;
        end
      end
      default:
      begin
        opc_state_next = OPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      opc_state_reg <= OPC_IDLE;
    else
      opc_state_reg <= opc_state_next;
  end

  // ---------------- standard event group ----------------
  always_comb
  begin
    std_if.set_bits = 8'h00;
    std_if.set_bits[`SE_CMD_ERR_BIT]   = CMD_ERR;
    std_if.set_bits[`SE_EXEC_ERR_BIT]  = EXEC_ERR;
    std_if.set_bits[`SE_DEV_ERR_BIT]   = DEV_ERR;
    std_if.set_bits[`SE_QUERY_ERR_BIT] = QUERY_ERR;
    std_if.set_bits[`SE_OP_DONE_BIT]   = opc_fire;
  end

  assign std_if.rd_clr   = queried(QUERY_STB, QUERY_SEL, Q_STD_EVENT);
  assign std_if.cls      = CLS_STB;
  assign std_if.ena_wr   = written(WR_STB, WR_SEL, W_STD_ENABLE);
  assign std_if.ena_data = WR_DATA;

  event_group
  #(
    .WIDTH     (`EVT_WIDTH),
    .USED_MASK (`SE_USED_MASK),
    .RESET_VAL (`STD_EVT_RESET)
  )
  u_std_group
  (
    .clk (REF_CLK),
    .rst (RST),
    .grp (std_if)
  );

  // ---------------- source condition and event group ----------------
  // sweep ready tracks live level
  always_comb
  begin
    src_cond_next = `COND_RESET;
    src_cond_next[`SRC_SWEEP_READY_BIT] = SWEEP_READY;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      src_cond_reg <= `COND_RESET;
    else
      src_cond_reg <= src_cond_next;
  end

  always_comb
  begin
    src_if.set_bits = rise(src_cond_next, src_cond_reg);
    src_if.set_bits[`SRC_SAMPLING_BIT]   = TRIG_EARLY;
    src_if.set_bits[`SRC_STORE_BIT]      = STORE_DONE;
    src_if.set_bits[`SRC_TURN_BIT]       = SWEEP_TURN_DONE;
    src_if.set_bits[`SRC_SWEEP_DONE_BIT] = SWEEP_DONE;
  end

  assign src_if.rd_clr   = queried(QUERY_STB, QUERY_SEL, Q_SRC_EVENT);
  assign src_if.cls      = CLS_STB;
  assign src_if.ena_wr   = written(WR_STB, WR_SEL, W_SRC_ENABLE);
  assign src_if.ena_data = WR_DATA;

  event_group
  #(
    .WIDTH     (`EVT_WIDTH),
    .USED_MASK (`SRC_USED_MASK),
    .RESET_VAL (`EVT_RESET)
  )
  u_src_group
  (
    .clk (REF_CLK),
    .rst (RST),
    .grp (src_if)
  );

  // ---------------- measurement condition and event group ----------------
  // live condition tracking
  always_comb
  begin
    meas_cond_next = `COND_RESET;
    meas_cond_next[`MEAS_OVERRANGE_BIT] = OVERRANGE_FLAG;
    meas_cond_next[`MEAS_HIGH_LIM_BIT]  = HIGH_LIMITER_ACTIVE;
    meas_cond_next[`MEAS_LOW_LIM_BIT]   = LOW_LIMITER_ACTIVE;
    meas_cond_next[`MEAS_ABOVE_BIT]     = COMPARE_ABOVE;
    meas_cond_next[`MEAS_BELOW_BIT]     = COMPARE_BELOW;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      meas_cond_reg <= `COND_RESET;
    else
      meas_cond_reg <= meas_cond_next;
  end

  always_comb
  begin
    meas_if.set_bits = rise(meas_cond_next, meas_cond_reg);
    meas_if.set_bits[`MEAS_SAMPLING_BIT] = TRIG_EARLY;
    meas_if.set_bits[`MEAS_DONE_BIT]     = MEASUREMENT_DONE;
  end

  assign meas_if.rd_clr   = queried(QUERY_STB, QUERY_SEL, Q_MEAS_EVENT);
  assign meas_if.cls      = CLS_STB;
  assign meas_if.ena_wr   = written(WR_STB, WR_SEL, W_MEAS_ENABLE);
  assign meas_if.ena_data = WR_DATA;

  event_group
  #(
    .WIDTH     (`EVT_WIDTH),
    .USED_MASK (`MEAS_USED_MASK),
    .RESET_VAL (`EVT_RESET)
  )
  u_meas_group
  (
    .clk (REF_CLK),
    .rst (RST),
    .grp (meas_if)
  );

  // ---------------- status byte ----------------
  // request enable survives clear-status
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      srq_enable_reg <= `ENA_RESET;
    else if (written(WR_STB, WR_SEL, W_SRQ_ENABLE))
      srq_enable_reg <= WR_DATA;
  end

  // each bit follows its own source only
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`SB_MEAS_SUM_BIT] = meas_if.summary;
    status_byte[`SB_SRC_SUM_BIT]  = src_if.summary;
    status_byte[`SB_ERRQ_BIT]     = ERR_QUEUE_NONEMPTY;
    status_byte[`SB_OUTQ_BIT]     = OUT_QUEUE_NONEMPTY;
    status_byte[`SB_STD_SUM_BIT]  = std_if.summary;
  end

  service_request u_service_request
  (
    .clk          (REF_CLK),
    .rst          (RST),
    .summary_bits (status_byte),
    .srq_enable   (srq_enable_reg),
    .poll         (is_poll),
    .mss          (mss),
    .rqs          (rqs)
  );

  // ---------------- query answers ----------------
  // answers show values before any clear of the same cycle takes effect
  always_comb
  begin
    rd_data_next = rd_data_reg;
    if (QUERY_STB)
    begin
      case (QUERY_SEL)
        Q_STATUS_BYTE:
        begin
          rd_data_next = status_byte;
          rd_data_next[`SB_SERVICE_BIT] = mss;
        end
        Q_SERIAL_POLL:
        begin
          rd_data_next = status_byte;
          rd_data_next[`SB_SERVICE_BIT] = rqs;
        end
        Q_STD_EVENT:   rd_data_next = std_if.event_q;
        Q_STD_ENABLE:  rd_data_next = std_if.enable_q;
        Q_SRQ_ENABLE:  rd_data_next = srq_enable_reg;
        Q_SRC_COND:    rd_data_next = src_cond_reg;
        Q_SRC_EVENT:   rd_data_next = src_if.event_q;
        Q_SRC_ENABLE:  rd_data_next = src_if.enable_q;
        Q_MEAS_COND:   rd_data_next = meas_cond_reg;
        Q_MEAS_EVENT:  rd_data_next = meas_if.event_q;
        Q_MEAS_ENABLE: rd_data_next = meas_if.enable_q;
        default:       rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rd_data_reg <= 8'h00;
    else
      rd_data_reg <= rd_data_next;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= QUERY_STB;
  end

  // ---------------- output queue flush ----------------
  // clear-status after terminator
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      flush_reg <= 1'b0;
    else
      flush_reg <= CLS_STB && AFTER_TERMINATOR;
  end

  assign RD_DATA         = rd_data_reg;
  assign RD_VALID        = rd_valid_reg;
  assign OUT_QUEUE_FLUSH = flush_reg;
  // request line carries the latch, so a serial poll drops it
  assign SRQ             = rqs;
endmodule

// *** tb/status_host.sv ***
// remote controller model issuing queries and enable writes
module status_host
(
  input  wire logic               clk,      // block clock
  input  wire logic [7:0]         rd_data,  // answer
  input  wire logic               rd_valid, // answer strobe
  output logic                    qstb,     // query request
  output status_pkg::query_e      qsel,     // queried register
  output logic                    wstb,     // enable write
  output status_pkg::write_e      wsel,     // written enable
  output logic [7:0]              wdata     // enable value
);
  timeunit 1ns;
  timeprecision 1ps;
  import status_pkg::*;
  initial
  begin
    qstb = 1'h0;
    qsel = Q_STATUS_BYTE;
    wstb = 1'h0;
    wsel = W_SRQ_ENABLE;
    wdata = 8'h00;
  end

  // bounded wait: a lost answer comes back with ok low
  task automatic query(input query_e s, output logic [7:0] d, output bit ok);
    @(posedge clk);
    qstb <= 1'h1;
    qsel <= s;
    @(posedge clk);
    qstb <= 1'h0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      #1;
      ok = (rd_valid === 1'h1);
      if (!ok)
        @(posedge clk);
    end
    d = rd_data;
  endtask

  task automatic write(input write_e s, input logic [7:0] d);
    @(posedge clk);
    wstb <= 1'h1;
    wsel <= s;
    wdata <= d;
    @(posedge clk);
    wstb <= 1'h0;
  endtask
endmodule

// *** tb/status_report_sva.sv ***
// protocol checker for the status reporting block, bound to its top module
module status_report_sva
(
  input wire logic               REF_CLK,            // block clock
  input wire logic               RST,                // synchronous reset
  input wire logic               QUERY_STB,          // query request
  input wire status_pkg::query_e QUERY_SEL,          // queried register
  input wire logic               CLS_STB,            // clear-status
  input wire logic               AFTER_TERMINATOR,   // terminator seen
  input wire logic               ERR_QUEUE_NONEMPTY, // error queue level
  input wire logic               OUT_QUEUE_NONEMPTY, // output queue level
  input wire logic               SWEEP_READY,        // sweep ready level
  input wire logic [7:0]         RD_DATA,            // answer
  input wire logic               RD_VALID,           // answer strobe
  input wire logic               OUT_QUEUE_FLUSH,    // flush pulse
  input wire logic               SRQ                 // request latch
);
  timeunit 1ns;
  timeprecision 1ps;
  import status_pkg::*;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  chk_answer_next : assert property (QUERY_STB |=> RD_VALID)
    else $error("query not answered next cycle");
  chk_no_stray : assert property (!QUERY_STB |=> !RD_VALID)
    else $error("answer strobe without query");
  chk_status_fixed : assert property (QUERY_STB && QUERY_SEL inside {Q_STATUS_BYTE, Q_SERIAL_POLL}
    |=> RD_DATA[7] == 1'h0 && RD_DATA[3] == 1'h0 && RD_DATA[2] == $past(ERR_QUEUE_NONEMPTY)
    && RD_DATA[4] == $past(OUT_QUEUE_NONEMPTY)) else $error("status byte queue bits wrong");
  chk_poll_latch : assert property (QUERY_STB && QUERY_SEL == Q_SERIAL_POLL
    |=> RD_DATA[6] == $past(SRQ)) else $error("serial poll bit 6 is not the latch");
  chk_flush_after : assert property (CLS_STB && AFTER_TERMINATOR |=> OUT_QUEUE_FLUSH)
    else $error("no flush after terminated clear");
  chk_flush_only : assert property (OUT_QUEUE_FLUSH |-> $past(CLS_STB) && $past(AFTER_TERMINATOR))
    else $error("flush without terminated clear");
  chk_std_unused : assert property (QUERY_STB && QUERY_SEL == Q_STD_EVENT
    |=> RD_DATA[6] == 1'h0 && RD_DATA[1] == 1'h0) else $error("unused standard bit set");
  chk_src_unused : assert property (QUERY_STB && QUERY_SEL == Q_SRC_EVENT
    |=> RD_DATA[6] == 1'h0 && RD_DATA[4:3] == 2'h0) else $error("unused source bit set");
  chk_meas_unused : assert property (QUERY_STB && QUERY_SEL == Q_MEAS_EVENT
    |=> RD_DATA[4] == 1'h0) else $error("unused measurement bit set");
  // guard keeps the two-deep look-back out of the reset cycles
  chk_src_cond : assert property (QUERY_STB && QUERY_SEL == Q_SRC_COND && !$past(RST)
    |=> RD_DATA == {2'h0, $past(SWEEP_READY, 2), 5'h00}) else $error("source condition wrong");
endmodule

bind status_report status_report_sva u_sva
(
  .REF_CLK(REF_CLK), .RST(RST), .QUERY_STB(QUERY_STB), .QUERY_SEL(QUERY_SEL), .CLS_STB(CLS_STB),
  .AFTER_TERMINATOR(AFTER_TERMINATOR), .ERR_QUEUE_NONEMPTY(ERR_QUEUE_NONEMPTY),
  .OUT_QUEUE_NONEMPTY(OUT_QUEUE_NONEMPTY), .SWEEP_READY(SWEEP_READY), .RD_DATA(RD_DATA),
  .RD_VALID(RD_VALID), .OUT_QUEUE_FLUSH(OUT_QUEUE_FLUSH), .SRQ(SRQ)
);

// *** tb/status_report_tb_top.sv ***
// self-checking bench of the status reporting block
module status_report_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import status_pkg::*;
  logic        clk;
  logic        rst;
  logic [10:0] ev;
  logic [9:0]  lv;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        flush;
  logic        srq;
  logic        fl;
  logic        qstb;
  query_e      qsel;
  logic        wstb;
  write_e      wsel;
  logic [7:0]  wdata;
  int          bad_count;
  int          n_checks;

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  status_host host
  (
    .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .qstb(qstb), .qsel(qsel),
    .wstb(wstb), .wsel(wsel), .wdata(wdata)
  );

  status_report DUT
  (
    .REF_CLK(clk), .RST(rst), .QUERY_STB(qstb), .QUERY_SEL(qsel), .WR_STB(wstb), .WR_SEL(wsel),
    .WR_DATA(wdata), .CLS_STB(ev[10]), .AFTER_TERMINATOR(lv[9]), .CMD_ERR(ev[0]), .EXEC_ERR(ev[1]),
    .DEV_ERR(ev[2]), .QUERY_ERR(ev[3]), .OPC_CMD(ev[4]), .OPS_IDLE(lv[0]), .ERR_QUEUE_NONEMPTY(lv[1]),
    .OUT_QUEUE_NONEMPTY(lv[2]), .TRIG_EARLY(ev[5]), .SWEEP_READY(lv[3]), .STORE_DONE(ev[6]),
    .SWEEP_TURN_DONE(ev[7]), .SWEEP_DONE(ev[8]), .MEASUREMENT_DONE(ev[9]), .OVERRANGE_FLAG(lv[4]),
    .HIGH_LIMITER_ACTIVE(lv[5]), .LOW_LIMITER_ACTIVE(lv[6]), .COMPARE_ABOVE(lv[7]),
    .COMPARE_BELOW(lv[8]), .RD_DATA(rd_data), .RD_VALID(rd_valid), .OUT_QUEUE_FLUSH(flush), .SRQ(srq)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic qc(input query_e s, input logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    host.query(s, d, ok);
    if (!ok)
    begin
      bad_count++;
      $display("unexpected at %0t: query not answered", $time);
      print_verdict();
    end
    else
      chk(d, e);
  endtask

  // one-cycle event pulses; the flush output is caught the cycle after
  task automatic pulse(input logic [10:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 11'h000;
    #1;
    fl = flush;
  endtask

  // extra edge lets the condition registers settle before a query
  task automatic setlv(input logic [9:0] v);
    @(posedge clk);
    lv <= v;
    repeat (2) @(posedge clk);
  endtask

  initial
  begin
    rst = 1'h1;
    ev = 11'h000;
    lv = 10'h000;
    fl = 1'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    qc(Q_STD_EVENT, 8'h80);
    qc(Q_STD_EVENT, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      pulse(11'h001 << i);
      qc(Q_STD_EVENT, 8'h20 >> i);
    end
    setlv(10'h001);
    pulse(11'h010);
    qc(Q_STD_EVENT, 8'h01);
    setlv(10'h000);
    pulse(11'h010);
    qc(Q_STD_EVENT, 8'h00);
    setlv(10'h001);
    qc(Q_STD_EVENT, 8'h01);
    $display("test standard events done");
    host.write(W_STD_ENABLE, 8'h20);
    host.write(W_SRQ_ENABLE, 8'h20);
    pulse(11'h001);
    qc(Q_STATUS_BYTE, 8'h60);
    qc(Q_STATUS_BYTE, 8'h60);
    chk({7'h00, srq}, 8'h01);
    qc(Q_SERIAL_POLL, 8'h60);
    qc(Q_SERIAL_POLL, 8'h20);
    host.write(W_STD_ENABLE, 8'h00);
    qc(Q_STATUS_BYTE, 8'h00);
    host.write(W_STD_ENABLE, 8'h20);
    qc(Q_STD_ENABLE, 8'h20);
    chk({7'h00, srq}, 8'h01);
    host.write(W_STD_ENABLE, 8'h00);
    qc(Q_STD_ENABLE, 8'h00);
    chk({7'h00, srq}, 8'h00);
    host.write(W_STD_ENABLE, 8'h20);
    setlv(10'h004);
    pulse(11'h400);
    chk({7'h00, fl}, 8'h00);
    qc(Q_STATUS_BYTE, 8'h10);
    qc(Q_STD_ENABLE, 8'h20);
    setlv(10'h204);
    pulse(11'h400);
    chk({7'h00, fl}, 8'h01);
    setlv(10'h002);
    host.write(W_SRQ_ENABLE, 8'h04);
    qc(Q_STATUS_BYTE, 8'h44);
    $display("test status byte done");
    setlv(10'h000);
    host.write(W_SRQ_ENABLE, 8'h02);
    host.write(W_SRC_ENABLE, 8'h01);
    qc(Q_SRQ_ENABLE, 8'h02);
    qc(Q_SRC_ENABLE, 8'h01);
    pulse(11'h1E0);
    qc(Q_STATUS_BYTE, 8'h42);
    qc(Q_SRC_EVENT, 8'h87);
    qc(Q_SRC_EVENT, 8'h00);
    setlv(10'h008);
    qc(Q_SRC_COND, 8'h20);
    qc(Q_SRC_COND, 8'h20);
    qc(Q_SRC_EVENT, 8'h20);
    $display("test source events done");
    host.write(W_MEAS_ENABLE, 8'h40);
    host.write(W_SRQ_ENABLE, 8'h01);
    setlv(10'h1F0);
    pulse(11'h220);
    qc(Q_STATUS_BYTE, 8'h41);
    qc(Q_MEAS_COND, 8'h2F);
    qc(Q_MEAS_EVENT, 8'hEF);
    qc(Q_MEAS_EVENT, 8'h00);
    setlv(10'h0F0);
    setlv(10'h1F0);
    qc(Q_MEAS_EVENT, 8'h01);
    setlv(10'h0F0);
    setlv(10'h1F0);
    pulse(11'h100);
    pulse(11'h400);
    qc(Q_MEAS_EVENT, 8'h00);
    qc(Q_SRC_EVENT, 8'h00);
    qc(Q_MEAS_ENABLE, 8'h40);
    qc(query_e'(4'hF), 8'h00);
    $display("test measurement events done");
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    qc(Q_STD_EVENT, 8'h80);
    qc(Q_MEAS_ENABLE, 8'h00);
    $display("test power cycle done");
    print_verdict();
  end
endmodule
